// >>> hw/mcis_cfg.svh
/*
  Constants of the microcore instruction subset: register indexes,
  opcode patterns, sizes, reset values and slew timing.
  Assumes it is included by its bare name from the core and the bench.
*/
`ifndef MCIS_CFG_SVH
`define MCIS_CFG_SVH

// ----------------------------------------------------------------
// Register indexes; the bus byte address is four times the index.
// ----------------------------------------------------------------
`define MCIS_IDX_OUT_GRANT_A 10'h184
`define MCIS_IDX_OUT_GRANT_B 10'h185
`define MCIS_IDX_OUT_GRANT_C 10'h186
`define MCIS_IDX_OUT_GRANT_D 10'h187
`define MCIS_IDX_CUR_GRANT_1 10'h188
`define MCIS_IDX_CUR_GRANT_2 10'h189
`define MCIS_IDX_STATUS 10'h18A
`define MCIS_IDX_STATE 10'h18B
`define MCIS_GRANT_RST 16'h0000

// ----------------------------------------------------------------
// Opcode patterns held in the fixed upper bits of each instruction, and for the store also in the two lowest bits.
// ----------------------------------------------------------------
`define MCIS_OPC_STOC 13'h06AA
`define MCIS_OPC_STORE_HI 2'h2
`define MCIS_OPC_STORE_LO 2'h1
`define MCIS_OPC_STOS 10'h0D1
`define MCIS_OPC_SLEW 15'h1ACB
`define MCIS_OPC_STSRB 11'h1B8
`define MCIS_OPC_SUB 7'h14

// ----------------------------------------------------------------
// Sizes and timing.
// ----------------------------------------------------------------
`define MCIS_NUM_OUT 12
`define MCIS_NUM_ALU 8
`define MCIS_SLEW_UP_CYC 1
`define MCIS_SLEW_DOWN_CYC 4

`endif

// >>> hw/mcis_pkg.sv
/*
  Types shared by the instruction subset: decoded operation,
  subtraction condition flags and the Data RAM write carrier.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mcis_pkg;

  // Decoded operation of the current instruction word.
  typedef enum logic [2:0] {
    MCIS_OP_NONE = 3'h0,
    MCIS_OP_OFS = 3'h1,
    MCIS_OP_STORE = 3'h2,
    MCIS_OP_SHORT = 3'h3,
    MCIS_OP_SLEW = 3'h4,
    MCIS_OP_STAT = 3'h5,
    MCIS_OP_SUB = 3'h6
  } mcis_op_t;

  // Condition flags left by a subtraction.
  typedef struct packed {
    logic zero_result_flag;
    logic negative_result_flag;
    logic unsigned_underflow_flag;
    logic unsigned_overflow_flag;
    logic signed_underflow_flag;
    logic signed_overflow_flag;
  } mcis_flags_t;

  // One Data RAM write: strobe, line address and data.
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [15:0] data;
  } mcis_dram_wr_t;

endpackage : mcis_pkg

// >>> hw/mcis_alu_sub.sv
/*
  Combinational 16-bit subtractor with its six condition flags.
  Assumes the caller registers both the result and the flags.
*/
module mcis_alu_sub (
  // Operands.
  input wire logic [15:0] minuend_i,
  input wire logic [15:0] subtrahend_i,
  // Result.
  output logic [15:0] diff_o,
  output mcis_pkg::mcis_flags_t flags_o
);

  // Difference with the borrow in the top bit.
  logic [16:0] wide;

  // ----------------------------------------------------------------
  // Difference and flags.
  // ----------------------------------------------------------------

  // The borrow marks an unsigned underflow; a subtraction of unsigned
  // values can never exceed the range upward.
  always_comb begin
    wide = {1'b0, minuend_i} - {1'b0, subtrahend_i};
    diff_o = wide[15:0];
    flags_o.zero_result_flag = (wide[15:0] == 16'h0000);
    flags_o.negative_result_flag = wide[15];
    flags_o.unsigned_underflow_flag = wide[16];
    flags_o.unsigned_overflow_flag = 1'b0;
    flags_o.signed_underflow_flag = minuend_i[15] & ~subtrahend_i[15] & ~wide[15];
    flags_o.signed_overflow_flag = ~minuend_i[15] & subtrahend_i[15] & wide[15];
  end

endmodule : mcis_alu_sub

// >>> hw/mcis_core.sv
/*
  Decode and execute of one instruction group of a gate-driver
  microcore: offset compensation, register store, shortcut outputs,
  slew mode, status bit set and two-register subtraction, with the
  access-right registers on a classic Wishbone slave.
  Assumes instruction, strap, base and shortcut inputs come from logic
  on clk_i, one instruction word per valid cycle.
*/
`include "mcis_cfg.svh"

module mcis_core (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Instruction stream and core context.
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [1:0] core_index_i,
  input wire logic [5:0] dram_base_i,
  input wire logic [11:0] shortcut_sel_i,
  // ALU register load from the rest of the core.
  input wire logic alu_load_i,
  input wire logic [2:0] alu_load_idx_i,
  input wire logic [15:0] alu_load_data_i,
  // Effects.
  output mcis_pkg::mcis_dram_wr_t dram_wr_o,
  output logic [3:0] ofs_comp_o,
  output logic [11:0] drive_state_o,
  output logic [11:0] slew_fast_o,
  output logic [15:0] status_o,
  output mcis_pkg::mcis_flags_t flags_o
);

  // ----------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------

  logic [15:0] out_grant_r [4]; // Drive rights, one register per core.
  logic [15:0] cur_grant_r [2]; // Current-block rights, two cores each.
  logic [15:0] alu_r [8]; // Arithmetic register subset.
  logic [3:0] ofs_r; // Offset compensation per block.
  logic [11:0] drive_r; // Pre-driver output states.
  logic [11:0] slew_req_r; // Requested fast mode per output.
  logic [11:0] slew_eff_r; // Effective fast mode per output.
  logic [15:0] status_r; // Status register.
  mcis_pkg::mcis_flags_t flags_r; // Condition flags.
  mcis_pkg::mcis_dram_wr_t dram_r; // Data RAM write strobe.
  logic ack_r; // Bus acknowledge.
  logic [31:0] rdat_r; // Bus read data.

  // ----------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------

  mcis_pkg::mcis_op_t op; // Decoded operation.
  logic [11:0] out_grant; // Drive rights of this core.
  logic [3:0] cur_grant; // Current-block rights of this core.
  logic [1:0] ofs_blk; // Block picked by the target field.
  logic [5:0] store_addr; // Data RAM line of a store.
  logic [15:0] store_src; // Value of the store source register.
  logic [11:0] drive_nxt; // Output states after a shortcut write.
  logic [11:0] slew_hit; // Outputs a slew write may touch.
  logic [15:0] sub_diff; // Subtraction result.
  mcis_pkg::mcis_flags_t sub_flags; // Subtraction flags.

  // Only the exact fixed opcode bits select an operation; the store also checks its two lowest bits.
  always_comb begin
    op = mcis_pkg::MCIS_OP_NONE;
    if (instr_valid_i) begin
      if (instr_i[15:3] == `MCIS_OPC_STOC) begin
        op = mcis_pkg::MCIS_OP_OFS;
      end else if (instr_i[15:14] == `MCIS_OPC_STORE_HI && instr_i[1:0] == `MCIS_OPC_STORE_LO) begin
        op = mcis_pkg::MCIS_OP_STORE;
      end else if (instr_i[15:6] == `MCIS_OPC_STOS) begin
        op = mcis_pkg::MCIS_OP_SHORT;
      end else if (instr_i[15:1] == `MCIS_OPC_SLEW) begin
        op = mcis_pkg::MCIS_OP_SLEW;
      end else if (instr_i[15:5] == `MCIS_OPC_STSRB) begin
        op = mcis_pkg::MCIS_OP_STAT;
      end else if (instr_i[15:9] == `MCIS_OPC_SUB) begin
        op = mcis_pkg::MCIS_OP_SUB;
      end
    end
  end

  // Rights of the issuing core; cores 0 and 1 sit in the first
  // current-block register, cores 2 and 3 in the second.
  always_comb begin
    out_grant = out_grant_r[core_index_i][11:0];
    cur_grant = core_index_i[0] ? cur_grant_r[core_index_i[1]][7:4] : cur_grant_r[core_index_i[1]][3:0];
  end

  // The target field flips the core bit and the channel bit.
  assign ofs_blk = core_index_i ^ instr_i[1:0];

  // Indexed mode adds the base, wrapping inside the 64 lines.
  assign store_addr = instr_i[13] ? instr_i[7:2] + dram_base_i : instr_i[7:2];

  // Source codes 0 to 7 are ALU registers, 8 the status register,
  // 9 the condition flags; the remaining codes read as zero.
  always_comb begin
    store_src = 16'h0000;
    if (instr_i[12:11] == 2'h0) begin
      store_src = alu_r[instr_i[10:8]];
    end else if (instr_i[12:8] == 5'h08) begin
      store_src = status_r;
    end else if (instr_i[12:8] == 5'h09) begin
      store_src = {10'h000, flags_r};
    end
  end

  // Each field acts on the output its shortcut names; unbound or
  // denied outputs keep their state, and a later field wins.
  always_comb begin
    logic [3:0] sel;
    logic [1:0] code;
    drive_nxt = drive_r;
    sel = 4'h0;
    code = 2'h0;
    for (int k = 0; k < 3; k++) begin
      sel = shortcut_sel_i[4*k +: 4];
      code = instr_i[4 - 2*k +: 2];
      if (sel < 4'hC && out_grant[sel]) begin
        unique case (code)
          2'h0: drive_nxt[sel] = drive_nxt[sel];
          2'h1: drive_nxt[sel] = 1'b0;
          2'h2: drive_nxt[sel] = 1'b1;
          2'h3: drive_nxt[sel] = ~drive_nxt[sel];
        endcase
      end
    end
  end

  // The slew write reaches every output this core may drive.
  assign slew_hit = out_grant;

  // Subtractor on the two named ALU registers.
  mcis_alu_sub u_sub (
    .minuend_i(alu_r[instr_i[2:0]]),
    .subtrahend_i(alu_r[instr_i[5:3]]),
    .diff_o(sub_diff),
    .flags_o(sub_flags)
  );

  // ----------------------------------------------------------------
  // Execute.
  // ----------------------------------------------------------------

  // Offset compensation follows the control bit when rights allow.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ofs_r <= 4'h0;
    end else if (op == mcis_pkg::MCIS_OP_OFS && cur_grant[ofs_blk]) begin
      ofs_r[ofs_blk] <= instr_i[2];
    end
  end

  // A store raises the write strobe for exactly one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dram_r <= '0;
    end else begin
      dram_r.we <= (op == mcis_pkg::MCIS_OP_STORE);
      if (op == mcis_pkg::MCIS_OP_STORE) begin
        dram_r.addr <= store_addr;
        dram_r.data <= store_src;
      end
    end
  end

  // Pre-driver states change only through shortcut writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_r <= 12'h000;
    end else if (op == mcis_pkg::MCIS_OP_SHORT) begin
      drive_r <= drive_nxt;
    end
  end

  // Requested slew mode per output; reset clears every request to slow mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slew_req_r <= 12'h000;
    end else if (op == mcis_pkg::MCIS_OP_SLEW) begin
      slew_req_r <= (slew_req_r & ~slew_hit) | ({12{instr_i[0]}} & slew_hit);
    end
  end

  // Each output speeds up one cycle after its request and slows down
  // four cycles after; a fresh request restarts the slow-down count.
  for (genvar g = 0; g < `MCIS_NUM_OUT; g++) begin : g_slew
    logic [1:0] cnt_r;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        slew_eff_r[g] <= 1'b0;
        cnt_r <= 2'h0;
      end else if (slew_req_r[g]) begin
        slew_eff_r[g] <= 1'b1;
        cnt_r <= 2'h0;
      end else if (slew_eff_r[g]) begin
        if (cnt_r == 2'(`MCIS_SLEW_DOWN_CYC - 1)) begin
          slew_eff_r[g] <= 1'b0;
          cnt_r <= 2'h0;
        end else begin
          cnt_r <= cnt_r + 2'h1;
        end
      end
    end
  end

  // Only the selected status bit takes the level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= 16'h0000;
    end else if (op == mcis_pkg::MCIS_OP_STAT) begin
      status_r[instr_i[3:0]] <= instr_i[4];
    end
  end

  // ALU registers take external loads; a subtraction wins a clash.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `MCIS_NUM_ALU; i++) begin
        alu_r[i] <= 16'h0000;
      end
      flags_r <= '0;
    end else begin
      if (alu_load_i) begin
        alu_r[alu_load_idx_i] <= alu_load_data_i;
      end
      if (op == mcis_pkg::MCIS_OP_SUB) begin
        alu_r[instr_i[8:6]] <= sub_diff;
        flags_r <= sub_flags;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave.
  // ----------------------------------------------------------------

  logic [9:0] idx; // Word index of the access.
  logic [31:0] rd_nxt; // Read data of the addressed register.
  logic wr_go; // Write takes effect this cycle.

  assign idx = wb_adr_i[11:2];
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;

  // Acknowledge one cycle after the strobe, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end

  // Grant registers take the two low byte lanes separately.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        out_grant_r[i] <= `MCIS_GRANT_RST;
      end
      cur_grant_r[0] <= `MCIS_GRANT_RST;
      cur_grant_r[1] <= `MCIS_GRANT_RST;
    end else if (wr_go) begin
      for (int i = 0; i < 4; i++) begin
        if (idx == `MCIS_IDX_OUT_GRANT_A + 10'(i)) begin
          if (wb_sel_i[0]) out_grant_r[i][7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) out_grant_r[i][15:8] <= wb_dat_i[15:8];
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (idx == `MCIS_IDX_CUR_GRANT_1 + 10'(i)) begin
          if (wb_sel_i[0]) cur_grant_r[i][7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cur_grant_r[i][15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // Read mux; unmapped words read as zero and are still acknowledged.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (idx)
      `MCIS_IDX_OUT_GRANT_A: rd_nxt[15:0] = out_grant_r[0];
      `MCIS_IDX_OUT_GRANT_B: rd_nxt[15:0] = out_grant_r[1];
      `MCIS_IDX_OUT_GRANT_C: rd_nxt[15:0] = out_grant_r[2];
      `MCIS_IDX_OUT_GRANT_D: rd_nxt[15:0] = out_grant_r[3];
      `MCIS_IDX_CUR_GRANT_1: rd_nxt[15:0] = cur_grant_r[0];
      `MCIS_IDX_CUR_GRANT_2: rd_nxt[15:0] = cur_grant_r[1];
      `MCIS_IDX_STATUS: rd_nxt[15:0] = status_r;
      `MCIS_IDX_STATE: rd_nxt[21:0] = {slew_eff_r, ofs_r, flags_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data is captured with the acknowledge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (wb_cyc_i & wb_stb_i & ~ack_r) begin
      rdat_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign dram_wr_o = dram_r;
  assign ofs_comp_o = ofs_r;
  assign drive_state_o = drive_r;
  assign slew_fast_o = slew_eff_r;
  assign status_o = status_r;
  assign flags_o = flags_r;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_OFS_SET: assert property (op == mcis_pkg::MCIS_OP_OFS && cur_grant[ofs_blk]
    |=> ofs_r[$past(ofs_blk)] == $past(instr_i[2])) else $error("compensation not set");
  AST_OFS_DENY: assert property (op == mcis_pkg::MCIS_OP_OFS && !cur_grant[ofs_blk]
    |=> $stable(ofs_r)) else $error("compensation changed without rights");
  AST_RST_OFS: assert property (disable iff (1'b0) rst_i
    |=> ofs_r == 4'h0 && slew_req_r == 12'h000) else $error("reset state wrong");
  AST_STORE: assert property (op == mcis_pkg::MCIS_OP_STORE
    |=> dram_r.we && dram_r.addr == $past(instr_i[13] ? instr_i[7:2] + dram_base_i : instr_i[7:2]))
    else $error("store address wrong");
  AST_SLEW_UP: assert property ($rose(slew_req_r[0]) |-> ##1 slew_eff_r[0])
    else $error("fast slew late");
  AST_SLEW_DOWN: assert property ($fell(slew_req_r[0]) && slew_eff_r[0] ##1 (!slew_req_r[0])[*3]
    |-> slew_eff_r[0] ##1 !slew_eff_r[0]) else $error("slow slew timing wrong");
  AST_STATUS: assert property (op == mcis_pkg::MCIS_OP_STAT
    |=> (status_r ^ $past(status_r)) == (($past(status_r[instr_i[3:0]]) ^ $past(instr_i[4])) << $past(instr_i[3:0])))
    else $error("status bits wrong");
  AST_SUB: assert property (op == mcis_pkg::MCIS_OP_SUB && !alu_load_i
    |=> alu_r[$past(instr_i[8:6])] == 16'($past(alu_r[instr_i[2:0]]) - $past(alu_r[instr_i[5:3]]))
    && flags_r.zero_result_flag == (alu_r[$past(instr_i[8:6])] == 16'h0000)) else $error("subtract wrong");
  AST_NOP: assert property (op == mcis_pkg::MCIS_OP_NONE
    |=> $stable(status_r) && $stable(ofs_r) && $stable(drive_r) && !dram_r.we) else $error("idle code acted");

  CV_STORE_IDX: cover property (op == mcis_pkg::MCIS_OP_STORE && instr_i[13]);
  CV_TOGGLE: cover property (op == mcis_pkg::MCIS_OP_SHORT && instr_i[5:4] == 2'h3 ##1 drive_r != 12'h000);
  CV_SLOW: cover property ($fell(slew_eff_r[0]));
  CV_BORROW: cover property (flags_r.unsigned_underflow_flag);

endmodule : mcis_core

// >>> verif/mcis_dram_model.sv
/*
  Data RAM stand-in at the far side of the block: it keeps every line
  that the block writes.
  Assumes the write carrier is registered on clk_i.
*/
module mcis_dram_model (
  // Clock.
  input wire logic clk_i,
  // Write carrier from the block.
  input wire mcis_pkg::mcis_dram_wr_t wr_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Sixty-four lines of sixteen bits, as the address field allows.
  logic [15:0] mem_r [64];

  // A line is stored at the edge that sees the write strobe.
  always_ff @(posedge clk_i) begin
    if (wr_i.we) begin
      mem_r[wr_i.addr] <= wr_i.data;
    end
  end
endmodule : mcis_dram_model

// >>> verif/tb_microcore_instruction_subset.sv
/*
  Self-checking bench for the instruction subset core: registers over
  classic Wishbone, a table of ordinary instructions, then slew, store,
  subtract and reset cases.
  Assumes mcis_pkg, mcis_core and the Data RAM model are compiled first.
*/
`include "mcis_cfg.svh"

module tb_microcore_instruction_subset;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // One table row: instruction, output looked at, expected value.
  typedef struct packed {
    logic [15:0] w;
    logic [1:0] k;
    logic [15:0] e;
  } mcis_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [1:0] core_index_i = 2'h0;
  logic [5:0] dram_base_i = 6'h00;
  // Shortcuts: first is output 0, second output 1, third output 9.
  logic [11:0] shortcut_sel_i = 12'h910;
  logic alu_load_i = 1'b0;
  logic [2:0] alu_load_idx_i = 3'h0;
  logic [15:0] alu_load_data_i = 16'h0000;
  mcis_pkg::mcis_dram_wr_t dram_wr_o;
  logic [3:0] ofs_comp_o;
  logic [11:0] drive_state_o, slew_fast_o;
  logic [15:0] status_o;
  mcis_pkg::mcis_flags_t flags_o;
  int n_fail = 0;
  int n_compared = 0;
  logic [31:0] rd;
  // Kind 0 is drive state, 1 offset compensation, 2 status; rows build on each other.
  mcis_row_t rows [14] = '{
    '{16'h3466, 2'h0, 16'h0001}, '{16'h347F, 2'h0, 16'h0002},
    '{16'h3448, 2'h0, 16'h0002}, '{16'h3452, 2'h0, 16'h0002},
    '{16'h3554, 2'h1, 16'h0001}, '{16'h3555, 2'h1, 16'h0001},
    '{16'h3556, 2'h1, 16'h0005}, '{16'h3557, 2'h1, 16'h0005},
    '{16'h3550, 2'h1, 16'h0004}, '{16'h3710, 2'h2, 16'h0001},
    '{16'h371F, 2'h2, 16'h8001}, '{16'h3717, 2'h2, 16'h8081},
    '{16'h3700, 2'h2, 16'h8080}, '{16'h3720, 2'h2, 16'h8080}
  };

  // ----------------------------------------------------------------
  // Design, far side and clock
  // ----------------------------------------------------------------
  mcis_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .core_index_i(core_index_i), .dram_base_i(dram_base_i), .shortcut_sel_i(shortcut_sel_i),
    .alu_load_i(alu_load_i), .alu_load_idx_i(alu_load_idx_i), .alu_load_data_i(alu_load_data_i),
    .dram_wr_o(dram_wr_o), .ofs_comp_o(ofs_comp_o), .drive_state_o(drive_state_o),
    .slew_fast_o(slew_fast_o), .status_o(status_o), .flags_o(flags_o));
  mcis_dram_model dram (.clk_i(clk_i), .wr_i(dram_wr_o));
  // A 50 ns period gives the 20 MHz clock.
  always #25 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Counts a comparison and reports a mismatch at once.
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One classic cycle; the request stands until ack is sampled high, and only the watchdog ends a wait.
  task wb(input logic we, input logic [9:0] idx, input logic [31:0] d, input logic [3:0] sel,
          output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // Presents one instruction; returns just after the edge that takes it.
  task issue(input logic [15:0] w);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask : issue
  // Loads one ALU register from the rest of the core.
  task alu_ld(input logic [2:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    alu_load_i <= 1'b1;
    alu_load_idx_i <= idx;
    alu_load_data_i <= d;
    @(posedge clk_i);
    alu_load_i <= 1'b0;
  endtask : alu_ld
  // Subtracts register 2 from register 1 into register 4, then stores register 4 to line 10.
  task do_sub(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    logic [5:0] f;
    d = a - b;
    f = {d == 16'h0000, d[15], a < b, 1'b0, a[15] & ~b[15] & ~d[15], ~a[15] & b[15] & d[15]};
    alu_ld(3'h1, a);
    alu_ld(3'h2, b);
    issue(16'h2911);
    chk("flags", {26'h0, flags_o}, {26'h0, f});
    issue(16'h8429);
    @(posedge clk_i);
    #1;
    chk("difference", {16'h0, dram.mem_r[10]}, {16'h0, d});
    $display("test subtract done");
  endtask : do_sub
  // Prints the counts and the verdict, then ends the run.
  task stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  // Cuts a hang short well beyond the hundred and sixty or so cycles the tests need.
  initial begin
    repeat (8000) @(posedge clk_i);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("outputs after reset", {4'h0, ofs_comp_o, drive_state_o, slew_fast_o}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, `MCIS_IDX_OUT_GRANT_A + 10'(i), 32'h0, 4'h3, rd);
      chk("grant after reset", rd, {16'h0, `MCIS_GRANT_RST});
    end
    // Byte lanes, upper half and an unmapped index.
    wb(1'b1, `MCIS_IDX_OUT_GRANT_D, 32'hFFFF_ABCD, 4'h3, rd);
    wb(1'b1, `MCIS_IDX_OUT_GRANT_D, 32'h0000_1111, 4'h1, rd);
    wb(1'b0, `MCIS_IDX_OUT_GRANT_D, 32'h0, 4'h3, rd);
    chk("byte lanes", rd, 32'h0000_AB11);
    wb(1'b1, 10'h190, 32'h0000_5555, 4'h3, rd);
    wb(1'b0, 10'h190, 32'h0, 4'h3, rd);
    chk("unmapped", rd, 32'h0);
    // Core 0 may drive outputs 0 to 7 and reach current blocks 0 and 2.
    wb(1'b1, `MCIS_IDX_OUT_GRANT_A, 32'h0000_00FF, 4'h3, rd);
    wb(1'b1, `MCIS_IDX_CUR_GRANT_1, 32'h0000_0005, 4'h3, rd);
    $display("test registers done");
    for (int i = 0; i < 14; i++) begin
      issue(rows[i].w);
      chk("row output", rows[i].k == 2'h0 ? {20'h0, drive_state_o} : rows[i].k == 2'h1 ?
          {28'h0, ofs_comp_o} : {16'h0, status_o}, {16'h0, rows[i].e});
    end
    wb(1'b1, `MCIS_IDX_STATUS, 32'h0000_FFFF, 4'h3, rd);
    wb(1'b0, `MCIS_IDX_STATUS, 32'h0, 4'h3, rd);
    chk("status read", rd, 32'h0000_8080);
    $display("test table done");
    // Slew up after one cycle, down after four, granted outputs only.
    issue(16'h3597);
    @(posedge clk_i);
    #1;
    chk("slew fast", {20'h0, slew_fast_o}, 32'h0FF);
    issue(16'h3596);
    repeat (3) @(posedge clk_i);
    #1;
    chk("slew held", {20'h0, slew_fast_o}, 32'h0FF);
    @(posedge clk_i);
    #1;
    chk("slew normal", {20'h0, slew_fast_o}, 32'h0);
    $display("test slew done");
    // Back-to-back stores, immediate then indexed with wrap past line 63.
    alu_ld(3'h3, 16'h1234);
    dram_base_i <= 6'h3C;
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= 16'h8315;
    @(posedge clk_i);
    instr_i <= 16'hA319;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("immediate store", {16'h0, dram.mem_r[5]}, 32'h1234);
    chk("indexed store", {16'h0, dram.mem_r[2]}, 32'h1234);
    $display("test store done");
    do_sub(16'h0005, 16'h0007);
    do_sub(16'h7FFF, 16'hFFFF);
    do_sub(16'h8000, 16'h0001);
    do_sub(16'h4321, 16'h4321);
    // Status and flags as store sources, then the read-only state word.
    issue(16'h882D);
    issue(16'h8931);
    @(posedge clk_i);
    #1;
    chk("status store", {16'h0, dram.mem_r[11]}, 32'h8080);
    chk("flags store", {16'h0, dram.mem_r[12]}, 32'h0020);
    wb(1'b0, `MCIS_IDX_STATE, 32'h0, 4'h3, rd);
    chk("state word", rd, 32'h0000_0120);
    $display("test sources done");
    // Reset in mid-run clears compensation and slew mode.
    issue(16'h3597);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk("outputs in reset", {4'h0, ofs_comp_o, drive_state_o, slew_fast_o}, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("outputs after release", {4'h0, ofs_comp_o, drive_state_o, slew_fast_o}, 32'h0);
    // Reset also clears the rights, so compensation is refused now.
    issue(16'h3554);
    chk("no rights after reset", {28'h0, ofs_comp_o}, 32'h0);
    $display("test reset done");
    stop_test();
  end
endmodule : tb_microcore_instruction_subset
